// [pio_device_end.sv]
// device end of the pio link with a write-data fifo
// assumes strobes and address arrive synchronous to clock_in
`timescale 1ns/1ps
`default_nettype none

// ========================================
// parameterised fifo, valid/ready on both sides
module pio_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr_r;
    logic [AW:0] rptr_r;
    logic push;
    logic pop;

    // refuse depths the pointer logic cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    // honest full and empty from pointer compare
    assign in_ready_out = !((wptr_r[AW] != rptr_r[AW]) &&
        (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
    assign out_valid_out = (wptr_r != rptr_r);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rptr_r[AW-1:0]];

    // storage
    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[wptr_r[AW-1:0]] <= in_data_in;
        end
    end

    // pointers
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end
endmodule

// ========================================
// device end
module pio_device_end #(
    parameter int FIFO_DEPTH = 8,
    parameter logic [2:0] DEV_MAX_MODE = 3'h4,
    parameter int DEV_CYCLE_NS = 120
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    pio_link_if.device_mp link,
    input wire logic mode_set_in,
    input wire logic [2:0] mode_in,
    output logic [2:0] mode_out,
    output logic iordy_en_out,
    output logic [15:0] ident_cycle_out,
    output logic wr_valid_out,
    input wire logic wr_ready_in,
    output logic [pio_timing_pkg::DATA_W-1:0] wr_data_out,
    input wire logic rd_valid_in,
    output logic rd_ready_out,
    input wire logic [pio_timing_pkg::DATA_W-1:0] rd_data_in,
    output logic drop_out
);
    import pio_timing_pkg::*;

    typedef enum logic [2:0] {
        D_IDLE, D_RD_WAIT, D_RD_DRIVE, D_WR_WAIT, D_WR_OPEN
    } dev_state_t;

    dev_state_t state_r;
    logic [2:0] mode_r;
    logic rd_prev_r;
    logic wr_prev_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] regs_r [8];
    logic stall_r;
    logic rd_fall;
    logic wr_fall;
    logic wr_rise;
    logic is_data;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic take_rd;

    // refuse parameter values the logic cannot serve
    if (DEV_MAX_MODE > MODE_MAX) begin : g_bad_mode
        $error("device max mode above 4");
    end else if (DEV_CYCLE_NS < REG_T0_NS[DEV_MAX_MODE] ||
        DEV_CYCLE_NS < DATA_T0_NS[DEV_MAX_MODE]) begin : g_bad_cycle
        $error("reported cycle time below mode minimum");
    end

    assign rd_fall = !link.rd_n && rd_prev_r;
    assign wr_fall = !link.wr_n && wr_prev_r;
    assign wr_rise = link.wr_n && !wr_prev_r && state_r == D_WR_OPEN;
    assign is_data = (addr_r == ADDR_DATA);
    assign iordy_en_out = (mode_r >= MODE_IORDY_MIN);
    assign mode_out = mode_r;
    // identify word 68 content, never below the claimed mode minimum
    assign ident_cycle_out = 16'(DEV_CYCLE_NS);
    // pop the read source when a data read is served
    assign take_rd = rd_valid_in && ((state_r == D_RD_WAIT && !link.rd_n) ||
        (state_r == D_IDLE && rd_fall && link.addr == ADDR_DATA));
    assign rd_ready_out = take_rd;
    assign fifo_in_valid = wr_rise && is_data;

    // link outputs: data only while a read strobe is served
    assign link.dd_d = rdata_r;
    assign link.dd_d_oe = (state_r == D_RD_DRIVE);
    assign link.iordy_d = 1'b0;
    assign link.iordy_d_oe = stall_r;

    // selected mode, slow default at power-up
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_r <= MODE_PWRUP;
        end else if (mode_set_in && mode_in <= DEV_MAX_MODE) begin
            mode_r <= mode_in;
        end
    end

    // strobe edge history
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
        end else begin
            rd_prev_r <= link.rd_n;
            wr_prev_r <= link.wr_n;
        end
    end

    // cycle sequencer; works from strobe edges only, so any
    // host split of assertion and recovery is served
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= D_IDLE;
            stall_r <= 1'b0;
            addr_r <= '0;
            rdata_r <= '0;
        end else begin
            case (state_r)
                D_IDLE: begin
                    if (rd_fall) begin
                        addr_r <= link.addr;
                        if (link.addr != ADDR_DATA) begin
                            rdata_r <= (link.addr[4:3] == CS_TASK_FILE) ?
                                regs_r[link.addr[2:0]] : '0;
                            state_r <= D_RD_DRIVE;
                        end else if (rd_valid_in) begin
                            rdata_r <= rd_data_in;
                            state_r <= D_RD_DRIVE;
                        end else if (iordy_en_out) begin
                            stall_r <= 1'b1;
                            state_r <= D_RD_WAIT;
                        end else begin
                            rdata_r <= '0;
                            state_r <= D_RD_DRIVE;
                        end
                    end else if (wr_fall) begin
                        addr_r <= link.addr;
                        if (link.addr == ADDR_DATA && !fifo_in_ready &&
                            iordy_en_out) begin
                            stall_r <= 1'b1;
                            state_r <= D_WR_WAIT;
                        end else begin
                            state_r <= D_WR_OPEN;
                        end
                    end
                end
                D_RD_WAIT: begin
                    if (link.rd_n) begin
                        stall_r <= 1'b0;
                        state_r <= D_IDLE;
                    end else if (rd_valid_in) begin
                        // data is registered here, iordy rises on this same edge
                        rdata_r <= rd_data_in;
                        stall_r <= 1'b0;
                        state_r <= D_RD_DRIVE;
                    end
                end
                D_RD_DRIVE: begin
                    if (link.rd_n) begin
                        state_r <= D_IDLE;
                    end
                end
                D_WR_WAIT: begin
                    if (fifo_in_ready || link.wr_n) begin
                        stall_r <= 1'b0;
                        state_r <= D_WR_OPEN;
                    end
                end
                D_WR_OPEN: begin
                    if (link.wr_n) begin
                        state_r <= D_IDLE;
                    end
                end
                default: begin
                    state_r <= D_IDLE;
                    stall_r <= 1'b0;
                end
            endcase
        end
    end

    // write data follows the bus while the strobe is low
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wdata_r <= '0;
        end else if (!link.wr_n) begin
            wdata_r <= link.dd;
        end
    end

    // task-file registers, written on strobe negation
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 8; i++) begin
                regs_r[i] <= '0;
            end
        end else if (wr_rise && !is_data && addr_r[4:3] == CS_TASK_FILE) begin
            regs_r[addr_r[2:0]] <= wdata_r;
        end
    end

    // overflow with no stretch possible
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            drop_out <= 1'b0;
        end else begin
            drop_out <= fifo_in_valid && !fifo_in_ready;
        end
    end

    pio_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(wdata_r),
        .out_valid_out(wr_valid_out),
        .out_ready_in(wr_ready_in),
        .out_data_out(wr_data_out)
    );
endmodule
`default_nettype wire

// [pio_timing_pkg.sv]
// pio cycle timing constants shared by host and device ends
// assumes a single 100 MHz clock on both ends
`default_nettype none
package pio_timing_pkg;

    // ========================================
    // clock and mode encoding
    localparam int CLK_PERIOD_NS = 10;
    localparam int NUM_MODES = 5;
    localparam logic [2:0] MODE_MAX = 3'h4;
    localparam logic [2:0] MODE_IORDY_MIN = 3'h3; // iordy from mode 3 up
    localparam logic [2:0] MODE_PWRUP = 3'h0; // one of the slow modes
    localparam int IDENT_CYCLE_WORD = 68; // identify word with cycle time

    // ========================================
    // link address layout: {cs1, cs0, da2, da1, da0}
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [1:0] CS_TASK_FILE = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 5'h10;

    // ========================================
    // per-mode minimum times in ns, index is the pio mode
    typedef int mode_tbl_t [NUM_MODES];
    localparam mode_tbl_t REG_T0_NS = '{600, 383, 330, 180, 120};
    localparam mode_tbl_t REG_T2_NS = '{290, 290, 290, 80, 70};
    localparam mode_tbl_t DATA_T0_NS = '{600, 383, 240, 180, 120};
    localparam mode_tbl_t DATA_T2_NS = '{165, 125, 100, 80, 70};
    localparam mode_tbl_t T2I_NS = '{0, 0, 0, 70, 25};
    localparam mode_tbl_t T1_NS = '{70, 50, 30, 30, 25};
    localparam mode_tbl_t T9_NS = '{20, 15, 10, 10, 10};
    localparam int TA_NS = 35;
    localparam int TA_CYC = (TA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // least time in ns to whole cycles, rounded up, never below one
    function automatic logic [7:0] ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        // saturate so a long device figure never wraps to a short count
        if (c > 255) begin
            c = 255;
        end
        return c[7:0];
    endfunction

endpackage
`default_nettype wire

// [pio_link_if.sv]
// parallel pio link between host end and device end
// assumes both ends share clock_in; dd and iordy are resolved here
`timescale 1ns/1ps
`default_nettype none
interface pio_link_if;
    import pio_timing_pkg::*;

    logic rd_n; // read strobe, active low
    logic wr_n; // write strobe, active low
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dd_h;
    logic dd_h_oe;
    logic [DATA_W-1:0] dd_d;
    logic dd_d_oe;
    logic iordy_d;
    logic iordy_d_oe;
    logic [DATA_W-1:0] dd;
    logic iordy;

    // ========================================
    // wire resolution: undriven bus floats high, iordy pulled up
    assign dd = dd_h_oe ? dd_h : (dd_d_oe ? dd_d : 16'hFFFF);
    assign iordy = iordy_d_oe ? iordy_d : 1'b1;

    modport host_mp (output rd_n, wr_n, addr, dd_h, dd_h_oe,
        input dd, iordy);
    modport device_mp (input rd_n, wr_n, addr, dd,
        output dd_d, dd_d_oe, iordy_d, iordy_d_oe);
endinterface
`default_nettype wire

// [pio_host_end.sv]
// host end of the pio link: strobe sequencer with mode timing
// assumes the device end shares clock_in on the same link
`timescale 1ns/1ps
`default_nettype none
module pio_host_end (
    input wire logic clock_in,
    input wire logic rstn_in,
    pio_link_if.host_mp link,
    input wire logic mode_load_in,
    input wire logic [2:0] mode_in,
    input wire logic [2:0] slowest_max_mode_in,
    input wire logic [15:0] dev_cycle_ns_in,
    output logic [2:0] mode_out,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_write_in,
    input wire logic [pio_timing_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [pio_timing_pkg::DATA_W-1:0] cmd_wdata_in,
    output logic rsp_valid_out,
    output logic [pio_timing_pkg::DATA_W-1:0] rsp_rdata_out
);
    import pio_timing_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE, H_SETUP, H_ACTIVE, H_RECOV
    } host_state_t;

    host_state_t state_r;
    logic [2:0] mode_r;
    // per-mode cycle counts, reloaded with the mode
    logic [7:0] t0_reg_r;
    logic [7:0] t0_data_r;
    logic [7:0] t2_reg_r;
    logic [7:0] t2_data_r;
    logic [7:0] t2i_r;
    logic [7:0] t1_r;
    logic [7:0] t9_r;
    logic [7:0] cnt_r;
    logic [7:0] since_r;
    logic write_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic wait_rdy_r;
    logic sampled_r;
    logic [2:0] eff_mode;
    logic [7:0] dev_cyc;
    logic is_data;
    logic [7:0] t0_need;
    logic [7:0] t2_need;
    logic [7:0] rec_need;
    logic iordy_en;
    logic strobe_done;
    logic [8:0] cyc_sum;

    // mode no faster than any attached device or the table
    assign eff_mode = (mode_in > slowest_max_mode_in) ?
        slowest_max_mode_in : mode_in;
    assign dev_cyc = ns_to_cyc(int'(dev_cycle_ns_in));

    // counts reload on every mode change
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_r <= MODE_PWRUP;
            t0_reg_r <= ns_to_cyc(REG_T0_NS[0]);
            t0_data_r <= ns_to_cyc(DATA_T0_NS[0]);
            t2_reg_r <= ns_to_cyc(REG_T2_NS[0]);
            t2_data_r <= ns_to_cyc(DATA_T2_NS[0]);
            t2i_r <= ns_to_cyc(T2I_NS[0]);
            t1_r <= ns_to_cyc(T1_NS[0]);
            t9_r <= ns_to_cyc(T9_NS[0]);
        end else if (mode_load_in && eff_mode <= MODE_MAX) begin
            mode_r <= eff_mode;
            t0_reg_r <= ns_to_cyc(REG_T0_NS[eff_mode]);
            t0_data_r <= ns_to_cyc(DATA_T0_NS[eff_mode]);
            t2_reg_r <= ns_to_cyc(REG_T2_NS[eff_mode]);
            t2_data_r <= ns_to_cyc(DATA_T2_NS[eff_mode]);
            t2i_r <= ns_to_cyc(T2I_NS[eff_mode]);
            t1_r <= ns_to_cyc(T1_NS[eff_mode]);
            t9_r <= ns_to_cyc(T9_NS[eff_mode]);
            // the device figure only governs modes 3 and up
            if (eff_mode >= MODE_IORDY_MIN) begin
                if (dev_cyc > ns_to_cyc(REG_T0_NS[eff_mode])) begin
                    t0_reg_r <= dev_cyc;
                end
                if (dev_cyc > ns_to_cyc(DATA_T0_NS[eff_mode])) begin
                    t0_data_r <= dev_cyc;
                end
            end
        end
    end

    assign mode_out = mode_r;
    assign iordy_en = (mode_r >= MODE_IORDY_MIN);
    assign is_data = (addr_r == ADDR_DATA);
    assign t0_need = is_data ? t0_data_r : t0_reg_r;
    assign t2_need = is_data ? t2_data_r : t2_reg_r;
    // recovery covers both negation minimum and address hold
    assign rec_need = (t2i_r > t9_r) ? t2i_r : t9_r;
    assign cyc_sum = {1'b0, since_r} + {1'b0, t1_r};
    // strobe may drop once width met and iordy is not holding it
    assign strobe_done = (cnt_r >= t2_need) && sampled_r &&
        !wait_rdy_r && (link.iordy || !iordy_en);

    assign cmd_ready_out = (state_r == H_IDLE);

    // link drive
    assign link.rd_n = !(state_r == H_ACTIVE && !write_r);
    assign link.wr_n = !(state_r == H_ACTIVE && write_r);
    assign link.addr = addr_r;
    assign link.dd_h = wdata_r;
    assign link.dd_h_oe = write_r && (state_r != H_IDLE);

    // cycle sequencer
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= H_IDLE;
            cnt_r <= '0;
            write_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end else begin
            case (state_r)
                H_IDLE: begin
                    if (cmd_valid_in) begin
                        write_r <= cmd_write_in;
                        addr_r <= cmd_addr_in;
                        wdata_r <= cmd_wdata_in;
                        cnt_r <= 8'h01;
                        state_r <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    // address setup before the strobe falls
                    if (cnt_r >= t1_r) begin
                        cnt_r <= 8'h01;
                        state_r <= H_ACTIVE;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                H_ACTIVE: begin
                    if (strobe_done) begin
                        cnt_r <= 8'h01;
                        state_r <= H_RECOV;
                    end else if (cnt_r != 8'hFF) begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                H_RECOV: begin
                    // next setup plus strobe spacing meets total cycle
                    if (cnt_r >= rec_need &&
                        cyc_sum >= {1'b0, t0_need}) begin
                        write_r <= 1'b0;
                        state_r <= H_IDLE;
                    end else if (cnt_r != 8'hFF) begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= H_IDLE;
                    write_r <= 1'b0;
                end
            endcase
        end
    end

    // cycles since the strobe fell, for the total cycle time
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            since_r <= '0;
        end else if (state_r == H_SETUP && cnt_r >= t1_r) begin
            since_r <= 8'h01;
        end else if (since_r != 8'hFF) begin
            since_r <= since_r + 8'h01;
        end
    end

    // iordy sampled a fixed delay after the strobe falls
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sampled_r <= 1'b0;
            wait_rdy_r <= 1'b0;
        end else if (state_r != H_ACTIVE) begin
            sampled_r <= 1'b0;
            wait_rdy_r <= 1'b0;
        end else if (!sampled_r && cnt_r >= 8'(TA_CYC)) begin
            sampled_r <= 1'b1;
            wait_rdy_r <= iordy_en && !link.iordy;
        end else if (wait_rdy_r && link.iordy) begin
            wait_rdy_r <= 1'b0;
        end
    end

    // read data taken as the strobe ends
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
        end else begin
            rsp_valid_out <= (state_r == H_ACTIVE) && strobe_done;
            if (state_r == H_ACTIVE && strobe_done && !write_r) begin
                rsp_rdata_out <= link.dd;
            end
        end
    end
endmodule
`default_nettype wire

// [pio_link_props.sv]
// wire-level checks for the pio link between host end and device end
// assumes the link signals sampled on clock_in, reset active low
`timescale 1ns/1ps
`default_nettype none
module pio_link_props (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [4:0] addr,
    input wire logic dd_h_oe,
    input wire logic dd_d_oe,
    input wire logic iordy_d_oe,
    input wire logic iordy
);
    // combined strobe, low while either strobe is asserted
    wire stb_n = rd_n & wr_n;
    logic stb_prev_r;
    logic [7:0] gap_r;
    wire stb_fall = !stb_n && stb_prev_r;

    // clocks since the previous strobe fall, saturating
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stb_prev_r <= 1'b1;
            gap_r <= 8'hFF;
        end else begin
            stb_prev_r <= stb_n;
            if (stb_fall) begin
                gap_r <= 8'h01;
            end else if (gap_r != 8'hFF) begin
                gap_r <= gap_r + 8'h01;
            end
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    // ========================================
    // strobe timing
    a_one_strobe: assert property (rd_n || wr_n)
        else $error("both strobes low");
    a_pulse_min: assert property ($fell(stb_n) |-> !stb_n [*7])
        else $error("strobe pulse too short");
    a_cycle_min: assert property (stb_fall |-> gap_r >= 8'h0C)
        else $error("cycle shorter than 12 clocks");
    a_recover_min: assert property ($rose(stb_n) |-> stb_n [*3])
        else $error("recovery too short");
    a_addr_hold: assert property (!stb_n && !$past(stb_n) |-> $stable(addr))
        else $error("address moved under strobe");

    // ========================================
    // ready handshake and data bus
    a_iordy_hold: assert property (!stb_n && !iordy |=> !stb_n)
        else $error("strobe ended while not ready");
    a_iordy_window: assert property (iordy_d_oe |-> !stb_n)
        else $error("ready held outside a cycle");
    a_data_ready: assert property (!rd_n && $rose(iordy) |-> dd_d_oe)
        else $error("ready returned before read data");
    a_bus_single: assert property (!(dd_h_oe && dd_d_oe))
        else $error("both ends drive the data bus");
endmodule
`default_nettype wire

// [tb_pio_cycle_timing.sv]
// bench for host end and device end joined by the pio link
// assumes the timing package, link interface, both ends and checker
`timescale 1ns/1ps
`default_nettype none
module tb_pio_cycle_timing;
    import pio_timing_pkg::*;
    logic clock_in = 0, rstn_in = 0, ml = 0, ms = 0, cv = 0, cw = 0;
    logic wrdy = 0, rdv = 0, cr, rv, ien, wv, rdr, drop;
    logic [2:0] mode = 3'h0, smax = 3'h4, hmode, dmode;
    logic [4:0] ca = 5'h00;
    logic [15:0] cd = 16'h0000, rdd = 16'hA5C3, rdat, ident, wdat, q;
    int errors = 0, n_compared = 0, drops = 0, lw = 0, wid = 0;
    time t0;

    always #5 clock_in = ~clock_in;

    // ========================================
    // both ends, the link and its checker
    pio_link_if pio_link_if_inst ();
    pio_host_end pio_host_end_inst (.clock_in(clock_in), .rstn_in(rstn_in),
        .link(pio_link_if_inst), .mode_load_in(ml), .mode_in(mode),
        .slowest_max_mode_in(smax), .dev_cycle_ns_in(ident),
        .mode_out(hmode), .cmd_valid_in(cv), .cmd_ready_out(cr),
        .cmd_write_in(cw), .cmd_addr_in(ca), .cmd_wdata_in(cd),
        .rsp_valid_out(rv), .rsp_rdata_out(rdat));
    pio_device_end #(.FIFO_DEPTH(8), .DEV_MAX_MODE(3'h4), .DEV_CYCLE_NS(120))
        pio_device_end_inst (.clock_in(clock_in), .rstn_in(rstn_in),
        .link(pio_link_if_inst), .mode_set_in(ms), .mode_in(mode),
        .mode_out(dmode), .iordy_en_out(ien), .ident_cycle_out(ident),
        .wr_valid_out(wv), .wr_ready_in(wrdy), .wr_data_out(wdat),
        .rd_valid_in(rdv), .rd_ready_out(rdr), .rd_data_in(rdd),
        .drop_out(drop));
    pio_link_props pio_link_props_inst (.clock_in(clock_in),
        .rstn_in(rstn_in), .rd_n(pio_link_if_inst.rd_n),
        .wr_n(pio_link_if_inst.wr_n), .addr(pio_link_if_inst.addr),
        .dd_h_oe(pio_link_if_inst.dd_h_oe),
        .dd_d_oe(pio_link_if_inst.dd_d_oe),
        .iordy_d_oe(pio_link_if_inst.iordy_d_oe),
        .iordy(pio_link_if_inst.iordy));

    // read source drops valid once a word is taken; drop counter
    always @(posedge clock_in) begin
        if (drop === 1'b1) drops++;
        if (rdr === 1'b1) #1 rdv = 1'b0;
    end

    // strobe low time of the latest cycle, in clocks
    always @(posedge clock_in) begin
        if (!(pio_link_if_inst.rd_n && pio_link_if_inst.wr_n)) begin
            lw++;
        end else if (lw != 0) begin
            wid = lw;
            lw = 0;
        end
    end

    // ========================================
    // tasks
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // bounded wait for a flag seen high at a rising edge
    task automatic wait_hi(ref logic s);
        int k;
        for (k = 0; k < 400 && s !== 1'b1; k++) @(posedge clock_in);
        if (s !== 1'b1) begin
            errors++;
            wrap_up;
        end
    endtask

    // one host command, held until taken, then wait for the answer
    task automatic op(input logic w, input logic [4:0] a,
        input logic [15:0] d);
        @(posedge clock_in);
        #1;
        cv = 1'b1;
        cw = w;
        ca = a;
        cd = d;
        @(posedge clock_in);
        wait_hi(cr);
        #1;
        cv = 1'b0;
        @(posedge clock_in);
        wait_hi(rv);
        q = rdat;
    endtask

    task automatic set_mode(input logic [2:0] m, input logic [2:0] s);
        @(posedge clock_in);
        #1;
        mode = m;
        smax = s;
        ml = 1'b1;
        ms = 1'b1;
        @(posedge clock_in);
        #1;
        ml = 1'b0;
        ms = 1'b0;
    endtask

    // ========================================
    // main sequence
    initial begin
        repeat (12) @(posedge clock_in);
        #1;
        rstn_in = 1'b1;
        chk("host mode", 16'h0000, {13'h0, hmode});
        chk("dev mode", 16'h0000, {13'h0, dmode});
        chk("cycle word", 16'h0078, ident);
        // task register write and read back in every mode
        for (int m = 0; m < NUM_MODES; m++) begin
            set_mode(m[2:0], 3'h4);
            chk("iordy en", {15'h0, m >= 3}, {15'h0, ien});
            op(1'b1, 5'h11 + m[4:0], 16'hC300 + m[15:0]);
            #1;
            chk("width", 16'h0001, {15'h0, wid * 10 >= REG_T2_NS[m]});
            op(1'b0, 5'h11 + m[4:0], 16'h0000);
            chk("task reg", 16'hC300 + m[15:0], q);
        end
        set_mode(3'h4, 3'h2);
        chk("capped mode", 16'h0002, {13'h0, hmode});
        // fill the fifo in mode 0; the ninth word is refused
        set_mode(3'h0, 3'h4);
        for (int k = 0; k < 9; k++) op(1'b1, ADDR_DATA, 16'h5A00 + k[15:0]);
        repeat (4) @(posedge clock_in);
        #1;
        chk("drops", 16'h0001, drops[15:0]);
        // drain with the far side stalling between words
        for (int k = 0; k < 8; k++) begin
            @(posedge clock_in);
            wait_hi(wv);
            chk("fifo word", 16'h5A00 + k[15:0], wdat);
            #1;
            wrdy = 1'b1;
            @(posedge clock_in);
            #1;
            wrdy = 1'b0;
            repeat (3) @(posedge clock_in);
        end
        chk("fifo empty", 16'h0000, {15'h0, wv});
        // mode 4 read with no data ready: device stretches the cycle
        set_mode(3'h4, 3'h4);
        t0 = $time;
        fork
            op(1'b0, ADDR_DATA, 16'h0000);
            begin
                repeat (30) @(posedge clock_in);
                #1;
                rdv = 1'b1;
            end
        join
        chk("read word", 16'hA5C3, q);
        chk("stretched", 16'h0001, {15'h0, $time - t0 >= 300});
        chk("source taken", 16'h0000, {15'h0, rdv});
        // mode 4 writes past a full fifo: device stretches, none dropped
        fork
            for (int k = 0; k < 9; k++) begin
                op(1'b1, ADDR_DATA, 16'h6B00 + k[15:0]);
            end
            begin
                repeat (200) @(posedge clock_in);
                #1;
                wrdy = 1'b1;
            end
        join
        chk("drops", 16'h0001, drops[15:0]);
        // second reset returns the device to a slow mode
        @(posedge clock_in);
        #1;
        rstn_in = 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        rstn_in = 1'b1;
        chk("dev mode", 16'h0000, {13'h0, dmode});
        wrap_up;
    end
endmodule
`default_nettype wire
